// ===== src/area_bus_ctrl.sv
// area external bus controller: areas, waits, idle cycles, bus release
//
// Functional notes
// - address strobe low only with valid address
// - read strobe low during external reads
// - byte write strobes per data half
// - low wait pin stretches three-state cycles
// - wait pin enable, off after reset
// - request low releases all bus pins
// - acknowledge low from one cycle into release until release ends
// - release enable, off after reset
// - eight 2-Mbyte areas, one select each
// - width setting 0 wide, 1 narrow
// - access setting 0 two, 1 three states
// - program waits only with three states
// - reset area width follows operating mode; states and waits reset to three
// - idle code selects idle insertion cases
// - area 0 basic or burst rom codes
// - address outputs enabled up to code plus 7
// - reset address range follows operating mode
// - settings act in modes 4-6 only
// - select driven only when direction bit set
// - three-state cycle lasts 3 to 6 states
// - release changes only at cycle end
// - select low for whole bus cycle
// - burst rom forces wide area 0
`timescale 1ns/1ps
`default_nettype none
module area_bus_ctrl
   import bus_ctrl_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic [2:0] op_mode,           // mode pins, sampled after reset release
   // settings from the cpu side
   input wire logic cfg_load,                // one-cycle strobe to take new settings
   input wire area_cfg_s cfg_in,
   input wire logic [1:0] idle_code_in,
   input wire logic [2:0] rom_mode_in,
   input wire logic wait_enable_in,
   input wire logic release_enable_in,
   input wire logic [4:0] addr_range_in,
   input wire logic [7:0] cs_dir,            // port direction bits per select
   // request side
   input wire req_s req,
   output logic req_ready,                   // one-cycle pulse: request taken
   output logic done,                        // one-cycle pulse: cycle finished
   output logic [DATA_W-1:0] rdata,
   // external pins
   input wire logic wait_n,
   input wire logic release_request_n,
   input wire logic [DATA_W-1:0] data_in,
   output pins_s pins,
   output logic release_ack_n,
   output logic [2:0] mode_seen             // captured operating mode
);

   // ==========================================
   // state
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ACCESS = 3'h1,
      ST_GAP = 3'h3,
      ST_RELEASED = 3'h2
   } state_e;

   state_e state_q;
   logic [2:0] count_q;                      // states spent in current cycle
   logic [2:0] len_q;                        // programmed length of current cycle
   logic bus_on_q;                           // external bus enabled in this mode
   logic boot_q;                             // loads mode defaults once after reset
   area_cfg_s cfg_q;
   logic [1:0] idle_q;
   logic [2:0] rom_q;
   logic wait_en_q;
   logic rel_en_q;
   logic [4:0] range_q;
   logic last_rd_q;                          // previous cycle was a read
   logic [2:0] last_area_q;
   req_s cur_q;
   logic [2:0] area;
   logic narrow;
   logic [2:0] cycle_len;
   logic wait_s1_q, wait_s2_q;               // wait pin synchroniser
   logic brq_s1_q, brq_s2_q;                 // request pin synchroniser
   logic want_release;
   logic need_gap;
   logic cycle_end;

   // shared decode of the incoming request's area
   area_decode u_decode (
      .addr(req.addr),
      .cfg(cfg_q),
      .rom_mode(rom_q),
      .area(area),
      .narrow(narrow),
      .cycle_len(cycle_len)
   );

   // mask of enabled address bits for a range code
   function automatic logic [ADDR_W-1:0] range_mask(input logic [4:0] code);
      logic [ADDR_W-1:0] m;
      m = '0;
      for (int i = 0; i < ADDR_W; i++)
      begin
         if (5'(i) <= 5'(code + ADDR_RANGE_BASE))
         begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   // ==========================================
   // pin synchronisers
   // both pins come from outside, two flops before use
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         wait_s1_q <= 1'b1;
         wait_s2_q <= 1'b1;
         brq_s1_q <= 1'b1;
         brq_s2_q <= 1'b1;
      end
      else
      begin
         wait_s1_q <= wait_n;
         wait_s2_q <= wait_s1_q;
         brq_s1_q <= release_request_n;
         brq_s2_q <= brq_s1_q;
      end
   end

   // ==========================================
   // settings
   // defaults are loaded one cycle after release, since the mode is a strap
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         boot_q <= 1'b1;
         mode_seen <= MODE_7;
         bus_on_q <= 1'b0;
         cfg_q <= '0;
         idle_q <= RESET_IDLE;
         rom_q <= RESET_ROM;
         wait_en_q <= 1'b0;
         rel_en_q <= 1'b0;
         range_q <= ADDR_RANGE_A7;
      end
      else if (boot_q)
      begin
         boot_q <= 1'b0;
         mode_seen <= op_mode;
         bus_on_q <= (op_mode >= MODE_4) && (op_mode <= MODE_6);
         cfg_q.width <= (op_mode == MODE_4) ? {8{WIDTH_16}} : {8{WIDTH_8}};
         cfg_q.states <= {8{STATES_3}};
         cfg_q.waits <= {8{RESET_WAITS}};
         range_q <= (op_mode == MODE_4 || op_mode == MODE_5) ? ADDR_RANGE_A20 : ADDR_RANGE_A7;
      end
      else if (cfg_load && bus_on_q)
      begin
         cfg_q <= cfg_in;
         idle_q <= idle_code_in;
         // only basic or the four burst codes are legal
         rom_q <= (rom_mode_in[2] || rom_mode_in == ROM_BASIC) ? rom_mode_in : rom_q;
         wait_en_q <= wait_enable_in;
         rel_en_q <= release_enable_in;
         range_q <= (addr_range_in > ADDR_RANGE_MAX) ? ADDR_RANGE_MAX : addr_range_in;
      end
   end

   // ==========================================
   // cycle control
   assign want_release = rel_en_q && !brq_s2_q;
   // idle cycle cases after a read
   assign need_gap = last_rd_q && (
      (idle_q[0] && req.write) ||
      (idle_q[1] && !req.write && area != last_area_q));
   // the cycle ends when its states are spent and no wait is held
   assign cycle_end = (state_q == ST_ACCESS) && (count_q >= len_q)
      && !(wait_en_q && !wait_s2_q && cfg_q.states[cur_q.addr[AREA_BIT_HI:AREA_BIT_LO]]);

   // main sequencer; release is only taken between cycles
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= ST_IDLE;
         count_q <= 3'h0;
         len_q <= BASE_STATES;
         cur_q <= '0;
         last_rd_q <= 1'b0;
         last_area_q <= 3'h0;
         req_ready <= 1'b0;
         done <= 1'b0;
         rdata <= '0;
      end
      else
      begin
         req_ready <= 1'b0;
         done <= 1'b0;
         case (state_q)
            ST_IDLE, ST_GAP:
            begin
               // the gap state is the single idle state; it takes requests like idle
               state_q <= ST_IDLE;
               if (want_release)
               begin
                  state_q <= ST_RELEASED;
               end
               else if (req.valid && bus_on_q && !boot_q)
               begin
                  if (need_gap)
                  begin
                     state_q <= ST_GAP;               // one idle state first
                     last_rd_q <= 1'b0;
                  end
                  else
                  begin
                     state_q <= ST_ACCESS;
                     cur_q <= req;
                     // narrow areas move only the low byte lane
                     cur_q.lanes <= narrow ? 2'h1 : req.lanes;
                     len_q <= cycle_len;
                     count_q <= 3'h1;
                     req_ready <= 1'b1;
                  end
               end
            end
            ST_ACCESS:
            begin
               if (cycle_end)
               begin
                  state_q <= ST_IDLE;
                  done <= 1'b1;
                  last_rd_q <= !cur_q.write;
                  last_area_q <= cur_q.addr[AREA_BIT_HI:AREA_BIT_LO];
                  rdata <= data_in;
               end
               else if (count_q < len_q)
               begin
                  count_q <= 3'(count_q + 3'h1);        // count stops at len_q; a held wait pin keeps the cycle open
               end
            end
            ST_RELEASED:
            begin
               if (!want_release)
               begin
                  state_q <= ST_IDLE;
               end
            end
            default:
            begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // pin drive
   // all outputs registered; strobes follow the sequencer's next step
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         pins <= '{as_n: 1'b1, rd_n: 1'b1, upper_wr_n: 1'b1, lower_wr_n: 1'b1, cs_n: 8'hff, default: '0};
         release_ack_n <= 1'b1;
      end
      else
      begin
         // acknowledge falls one cycle after entering the released state, rises on leaving it
         release_ack_n <= !(state_q == ST_RELEASED && want_release);
         if (state_q == ST_RELEASED || (state_q == ST_IDLE && want_release))
         begin
            pins <= '{as_n: 1'b1, rd_n: 1'b1, upper_wr_n: 1'b1, lower_wr_n: 1'b1, cs_n: 8'hff, default: '0};
         end
         else if (state_q == ST_ACCESS && !cycle_end)
         begin
            pins.addr <= cur_q.addr;
            pins.addr_oe <= range_mask(range_q);
            pins.as_n <= 1'b0;
            pins.strobe_oe <= 1'b1;
            pins.rd_n <= cur_q.write;
            pins.upper_wr_n <= !(cur_q.write && cur_q.lanes[1]);
            pins.lower_wr_n <= !(cur_q.write && cur_q.lanes[0]);
            pins.data <= cur_q.wdata;
            pins.data_oe <= cur_q.write ? {{8{cur_q.lanes[1]}}, {8{cur_q.lanes[0]}}} : 16'h0000;
            for (int i = 0; i < AREA_COUNT; i++)
            begin
               // select for the addressed area, whole cycle long
               pins.cs_n[i] <= !(cur_q.addr[AREA_BIT_HI:AREA_BIT_LO] == 3'(i));
               pins.cs_oe[i] <= cs_dir[i];
            end
         end
         else
         begin
            // between cycles keep address, drop strobes and selects
            pins.as_n <= 1'b1;
            pins.rd_n <= 1'b1;
            pins.upper_wr_n <= 1'b1;
            pins.lower_wr_n <= 1'b1;
            pins.cs_n <= 8'hff;
            pins.cs_oe <= bus_on_q ? cs_dir : 8'h00;
            pins.strobe_oe <= bus_on_q;
            pins.addr_oe <= bus_on_q ? range_mask(range_q) : '0;
            pins.data_oe <= '0;
         end
      end
   end

endmodule
`default_nettype wire

// ===== src/bus_ctrl_pkg.sv
// shared constants and carrier types for the area external bus controller
package bus_ctrl_pkg;

   // ==========================================
   // geometry
   localparam int AREA_COUNT = 8;               // eight areas of the external space
   localparam int AREA_BIT_HI = 23;             // area number sits in address bits 23..21
   localparam int AREA_BIT_LO = 21;             // 2-Mbyte areas
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;

   // ==========================================
   // setting codes
   localparam logic [0:0] WIDTH_16 = 1'h0;      // width setting: 16-bit bus
   localparam logic [0:0] WIDTH_8 = 1'h1;       // width setting: 8-bit bus
   localparam logic [0:0] STATES_2 = 1'h0;      // access-state setting: 2 states
   localparam logic [0:0] STATES_3 = 1'h1;      // access-state setting: 3 states
   localparam logic [1:0] IDLE_NONE = 2'h0;
   localparam logic [1:0] IDLE_RD_WR = 2'h1;    // idle before a write after a read
   localparam logic [1:0] IDLE_RD_RD = 2'h2;    // idle between reads to different areas
   localparam logic [1:0] IDLE_BOTH = 2'h3;
   localparam logic [2:0] ROM_BASIC = 3'h0;
   localparam logic [2:0] ROM_B1_4 = 3'h4;      // 1-state bursts, up to 4 words
   localparam logic [2:0] ROM_B1_8 = 3'h5;      // 1-state bursts, up to 8 words
   localparam logic [2:0] ROM_B2_4 = 3'h6;      // 2-state bursts, up to 4 words
   localparam logic [2:0] ROM_B2_8 = 3'h7;      // 2-state bursts, up to 8 words
   localparam logic [4:0] ADDR_RANGE_MAX = 5'h10;
   localparam logic [4:0] ADDR_RANGE_BASE = 5'h07; // top enabled bit = code plus this
   localparam logic [4:0] ADDR_RANGE_A20 = 5'h0d;  // reset code for modes 4 and 5
   localparam logic [4:0] ADDR_RANGE_A7 = 5'h00;   // reset code for modes 6 and 7

   // ==========================================
   // operating modes and reset values
   localparam logic [2:0] MODE_4 = 3'h4;
   localparam logic [2:0] MODE_5 = 3'h5;
   localparam logic [2:0] MODE_6 = 3'h6;
   localparam logic [2:0] MODE_7 = 3'h7;
   localparam logic [1:0] RESET_WAITS = 2'h3;
   localparam logic [1:0] RESET_IDLE = IDLE_BOTH;
   localparam logic [2:0] RESET_ROM = ROM_BASIC;
   localparam logic [2:0] BASE_STATES = 3'h2;   // shortest basic cycle in states

   // ==========================================
   // carriers
   typedef struct packed {
      logic [7:0] width;        // per area: 1 = 8-bit
      logic [7:0] states;       // per area: 1 = three states
      logic [15:0] waits;       // per area: two bits of program waits
   } area_cfg_s;

   typedef struct packed {
      logic valid;              // request pending
      logic write;              // 1 = write, 0 = read
      logic [1:0] lanes;        // [1] upper byte, [0] lower byte
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } req_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [ADDR_W-1:0] addr_oe;
      logic [DATA_W-1:0] data;
      logic [DATA_W-1:0] data_oe;
      logic [7:0] cs_n;
      logic [7:0] cs_oe;
      logic as_n;
      logic rd_n;
      logic upper_wr_n;
      logic lower_wr_n;
      logic strobe_oe;          // enable for strobes
   } pins_s;

endpackage

// ===== src/area_decode.sv
// area decoder: picks the area and that area's cycle settings
`timescale 1ns/1ps
`default_nettype none
module area_decode
   import bus_ctrl_pkg::*;
(
   input wire logic [ADDR_W-1:0] addr,
   input wire area_cfg_s cfg,
   input wire logic [2:0] rom_mode,
   output logic [2:0] area,
   output logic narrow,
   output logic [2:0] cycle_len
);

   // ==========================================
   // combinational decode
   // area from the top three address bits
   always_comb
   begin
      area = addr[AREA_BIT_HI:AREA_BIT_LO];
      // burst rom forces area 0 to the wide bus
      if (area == 3'h0 && rom_mode[2])
      begin
         narrow = 1'b0;
      end
      else
      begin
         narrow = cfg.width[area];
      end
      // three states plus program waits, else two
      if (cfg.states[area] == STATES_3)
      begin
         cycle_len = 3'(BASE_STATES + 3'h1 + {1'b0, cfg.waits[area*2 +: 2]});
      end
      else
      begin
         cycle_len = BASE_STATES;
      end
   end

endmodule
`default_nettype wire

// ===== sim/area_bus_ctrl_props.sv
// port assertions for the area external bus controller
`timescale 1ns/1ps
`default_nettype none
module area_bus_ctrl_props
   import bus_ctrl_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic cfg_load,
   input wire logic release_enable_in,
   input wire logic [7:0] cs_dir,
   input wire req_s req,
   input wire logic req_ready,
   input wire logic done,
   input wire pins_s pins,
   input wire logic release_ack_n,
   input wire logic [2:0] mode_seen
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   // ==========================================
   // release enable as the design ought to hold it
   logic rel_en_q; // off after reset, loaded only outside mode 7
   // tracks the setting so the ack can be tied to it
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         rel_en_q <= 1'b0;
      else if (cfg_load && mode_seen != MODE_7)
         rel_en_q <= release_enable_in;
   end
   // ==========================================
   // pin relations
   property p_as_addr;
      !pins.as_n |-> pins.strobe_oe && pins.addr_oe[7:0] == 8'hff;
   endproperty
   a_as_addr: assert property (p_as_addr) else $error("strobe without address");
   property p_read;
      req_ready && !req.write |=> !pins.rd_n && !pins.as_n;
   endproperty
   a_read: assert property (p_read) else $error("read strobe missing");
   property p_done_idle;
      done |-> pins.as_n && pins.rd_n;
   endproperty
   a_done_idle: assert property (p_done_idle) else $error("strobes low at cycle end");
   property p_upper;
      !pins.upper_wr_n |-> pins.rd_n && pins.data_oe[15:8] == 8'hff;
   endproperty
   a_upper: assert property (p_upper) else $error("upper write without data");
   property p_released;
      !release_ack_n |-> !pins.strobe_oe && pins.addr_oe == '0 && pins.data_oe == '0 && pins.cs_oe == '0;
   endproperty
   a_released: assert property (p_released) else $error("pins driven while released");
   property p_one_cs;
      $onehot0(~pins.cs_n);
   endproperty
   a_one_cs: assert property (p_one_cs) else $error("two selects low");
   property p_mode7;
      mode_seen == MODE_7 |-> !req_ready && pins.as_n;
   endproperty
   a_mode7: assert property (p_mode7) else $error("bus cycle in mode 7");
   property p_dir;
      $stable(cs_dir) |-> (pins.cs_oe & ~cs_dir) == 8'h00;
   endproperty
   a_dir: assert property (p_dir) else $error("select driven as input");
   property p_ack_edge;
      $changed(release_ack_n) |-> pins.as_n && $past(pins.as_n);
   endproperty
   a_ack_edge: assert property (p_ack_edge) else $error("ack moved in a cycle");
   property p_ack_off;
      !rel_en_q |=> release_ack_n;
   endproperty
   a_ack_off: assert property (p_ack_off) else $error("ack low while disabled");
endmodule
bind area_bus_ctrl area_bus_ctrl_props i_props (.clock(clock), .resetn(resetn), .cfg_load(cfg_load),
   .release_enable_in(release_enable_in), .cs_dir(cs_dir), .req(req), .req_ready(req_ready),
   .done(done), .pins(pins), .release_ack_n(release_ack_n), .mode_seen(mode_seen));
`default_nettype wire

// ===== sim/ext_party.sv
// far side model: external memory, wait source and external bus master
`timescale 1ns/1ps
`default_nettype none
module ext_party
   import bus_ctrl_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire pins_s pins,
   input wire logic [3:0] hold_len, // wait states asked per cycle
   input wire logic want_bus, // master wants the bus
   output logic [DATA_W-1:0] data_in,
   output logic wait_n,
   output logic release_request_n
);
   // ==========================================
   // memory and wait source
   logic [DATA_W-1:0] last_q; // last value on the data lines
   logic as_q; // strobe one cycle back
   logic [3:0] wcnt_q; // wait states still owed
   // drive only on a read; else flip so a stale value never passes
   always_comb
   begin
      if (pins.strobe_oe && !pins.rd_n)
         data_in = {pins.addr[7:0], ~pins.addr[7:0]} ^ 16'h3c5a;
      else
         data_in = ~last_q;
   end
   // wait count starts at each falling address strobe
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         last_q <= '0;
         as_q <= 1'b1;
         wcnt_q <= '0;
      end
      else
      begin
         last_q <= data_in;
         as_q <= pins.as_n;
         if (as_q && !pins.as_n)
            wcnt_q <= hold_len;
         else if (wcnt_q != 4'h0)
            wcnt_q <= wcnt_q - 4'h1;
      end
   end
   assign wait_n = (wcnt_q == 4'h0);
   assign release_request_n = !want_bus;
endmodule
`default_nettype wire

// ===== sim/test_area_bus_ctrl.sv
// self-checking testbench for the area external bus controller
`timescale 1ns/1ps
`default_nettype none
module test_area_bus_ctrl
   import bus_ctrl_pkg::*;
;
   // ==========================================
   // signals
   logic clock = 1'b0;
   logic resetn, cfg_load, wait_enable_in, release_enable_in, want_bus;
   logic req_ready, done, wait_n, release_request_n, release_ack_n;
   logic [2:0] op_mode, rom_mode_in, mode_seen;
   logic [1:0] idle_code_in;
   logic [4:0] addr_range_in;
   logic [7:0] cs_dir, cs_low, cs_oe_seen;
   logic [3:0] hold_len; // wait states the far side asks for
   logic [DATA_W-1:0] rdata, data_in;
   logic [ADDR_W-1:0] a_oe_seen;
   logic up_seen, lo_seen; // write strobes seen in the last cycle
   area_cfg_s cfg_in;
   req_s req;
   pins_s pins;
   int seed = 81;
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0; // cycle count for gap timing
   int len, t_rdy, t_done, t_prev;
   always #25 clock = ~clock;
   // free cycle counter
   always @(posedge clock) cyc <= cyc + 1;
   area_bus_ctrl i_dut (.clock(clock), .resetn(resetn), .op_mode(op_mode), .cfg_load(cfg_load),
      .cfg_in(cfg_in), .idle_code_in(idle_code_in), .rom_mode_in(rom_mode_in),
      .wait_enable_in(wait_enable_in), .release_enable_in(release_enable_in),
      .addr_range_in(addr_range_in), .cs_dir(cs_dir), .req(req), .req_ready(req_ready),
      .done(done), .rdata(rdata), .wait_n(wait_n), .release_request_n(release_request_n),
      .data_in(data_in), .pins(pins), .release_ack_n(release_ack_n), .mode_seen(mode_seen));
   ext_party i_far (.clock(clock), .resetn(resetn), .pins(pins), .hold_len(hold_len), .want_bus(want_bus),
      .data_in(data_in), .wait_n(wait_n), .release_request_n(release_request_n));
   // ==========================================
   // tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic do_reset(input logic [2:0] m);
      resetn <= 1'b0;
      op_mode <= m;
      repeat (5) @(posedge clock);
      {resetn, want_bus} <= 2'h2;
      repeat (2) @(posedge clock);
   endtask
   task automatic load(input area_cfg_s c, input logic [1:0] ic, input logic [2:0] rm, input logic we,
      input logic re, input logic [4:0] ar);
      @(posedge clock);
      {cfg_in, idle_code_in, rom_mode_in, wait_enable_in, release_enable_in, addr_range_in} <= {c, ic, rm, we, re, ar};
      cfg_load <= 1'b1;
      @(posedge clock);
      cfg_load <= 1'b0;
   endtask
   // one request held until taken; notes what the pins showed up to done
   task automatic xfer(input logic wr, input logic [23:0] a, input logic [1:0] ln);
      int k;
      t_prev = t_done;
      @(posedge clock);
      req <= '{1'b1, wr, ln, a, ~a[15:0]};
      {up_seen, lo_seen, cs_low, cs_oe_seen, len} = '0;
      for (k = 0; k < 40 && req_ready !== 1'b1; k++)
      begin
         @(posedge clock);
         #1;
      end
      check("taken", req_ready, 1'b1);
      t_rdy = cyc;
      a_oe_seen = pins.addr_oe;
      while (done !== 1'b1 && len < 40)
      begin
         up_seen |= ~pins.upper_wr_n;
         lo_seen |= ~pins.lower_wr_n;
         cs_low |= ~pins.cs_n;
         cs_oe_seen |= pins.cs_oe;
         @(posedge clock);
         req.valid <= 1'b0;
         #1;
         len++;
      end
      t_done = cyc;
      if (!wr)
         check("read data", rdata, {a[7:0], ~a[7:0]} ^ 16'h3c5a);
   endtask
   task automatic wait_ack(input logic v);
      int k;
      for (k = 0; k < 20 && release_ack_n !== v; k++)
      begin
         @(posedge clock);
         #1;
      end
      check("release ack", release_ack_n, v);
   endtask
   function automatic int exp_len(input area_cfg_s c, input int i);
      return c.states[i] ? 3 + c.waits[2*i+:2] : 2;
   endfunction
   // ==========================================
   // main sequence
   initial
   begin
      int m, i, j, g0, g1, ga, gb;
      area_cfg_s c;
      logic [23:0] a;
      {resetn, op_mode, cfg_load, cfg_in, idle_code_in, rom_mode_in, wait_enable_in} = '0;
      {release_enable_in, addr_range_in, req, want_bus} = '0;
      {cs_dir, hold_len} = 12'hff4;
      // defaults in each bus mode, far side asking for the bus all along
      for (m = 4; m < 7; m++)
      begin
         do_reset(3'(m));
         want_bus <= 1'b1;
         check("mode", mode_seen, m);
         xfer(1'b0, 24'h400010, 2'h1);
         check("reset len", len, 6);
         check("ack idle", release_ack_n, 1'b1);
         xfer(1'b1, 24'h400012, 2'h3);
         check("reset width", up_seen, m == 4);
         check("reset range", a_oe_seen, m == 6 ? 24'hff : 24'h1fffff);
      end
      $display("test reset defaults done");
      // random area settings, a read and a write in every area
      for (i = 0; i < 4; i++)
      begin
         c = $random(seed);
         load(c, IDLE_NONE, ROM_BASIC, 1'b0, 1'b0, ADDR_RANGE_MAX);
         for (j = 0; j < 8; j++)
         begin
            a = {3'(j), 21'($random(seed))};
            xfer(1'b0, a, 2'h3);
            check("cycle len", len, exp_len(c, j));
            xfer(1'b1, a, 2'h3);
            check("upper strobe", up_seen, !c.width[j]);
            check("lower strobe", lo_seen, 1'b1);
            check("select", cs_low, 8'h1 << j);
         end
      end
      // every range code, plus one past the top which clamps
      for (i = 0; i < 18; i++)
      begin
         load(c, IDLE_NONE, ROM_BASIC, 1'b0, 1'b0, 5'(i));
         xfer(1'b0, 24'h200000, 2'h1);
         check("addr range", a_oe_seen, 24'((33'h1 << (i > 16 ? 24 : i + 8)) - 1));
      end
      $display("test areas and ranges done");
      // wait pin ignored, then obeyed
      // three waits, so the synchronised pin arrives before the cycle would end
      c = '{8'h00, 8'hff, 16'hffff};
      for (i = 0; i < 2; i++)
      begin
         load(c, IDLE_NONE, ROM_BASIC, 1'(i), 1'b0, ADDR_RANGE_MAX);
         xfer(1'b0, 24'h600000, 2'h3);
         check("wait stretch", len > 6, i);
      end
      // idle codes: read then write, then reads to two areas
      c = '0;
      for (i = 0; i < 4; i++)
      begin
         load(c, 2'(i), ROM_BASIC, 1'b0, 1'b0, ADDR_RANGE_MAX);
         xfer(1'b0, 24'h200000, 2'h3);
         xfer(1'b1, 24'h200002, 2'h3);
         ga = t_rdy - t_prev;
         xfer(1'b0, 24'h400000, 2'h3);
         xfer(1'b0, 24'h200000, 2'h3);
         gb = t_rdy - t_prev;
         if (i == 0)
            {g0, g1} = {ga, gb};
         check("idle after read", ga, g0 + i % 2);
         check("idle across areas", gb, g1 + i / 2);
      end
      $display("test wait and idle done");
      // burst codes force area 0 wide even when set narrow
      c = '{8'hff, 8'h00, 16'h0};
      for (i = 3; i < 8; i++)
      begin
         load(c, IDLE_NONE, i == 3 ? ROM_BASIC : 3'(i), 1'b0, 1'b0, ADDR_RANGE_MAX);
         xfer(1'b1, 24'h000100, 2'h3);
         check("burst width", up_seen, i > 3);
      end
      // select pin turned to input
      @(posedge clock);
      cs_dir <= 8'hf7;
      xfer(1'b1, 24'h600000, 2'h1);
      check("select off", cs_oe_seen[3], 1'b0);
      @(posedge clock);
      cs_dir <= 8'hff;
      xfer(1'b1, 24'h600000, 2'h1);
      check("select on", cs_oe_seen[3], 1'b1);
      // release granted, pins float, then bus taken back
      load(c, IDLE_NONE, ROM_BASIC, 1'b0, 1'b1, ADDR_RANGE_MAX);
      want_bus <= 1'b1;
      wait_ack(1'b0);
      check("released oe", |{pins.addr_oe, pins.data_oe, pins.cs_oe, pins.strobe_oe}, 1'b0);
      @(posedge clock);
      want_bus <= 1'b0;
      wait_ack(1'b1);
      xfer(1'b0, 24'h200000, 2'h1);
      load(c, IDLE_NONE, ROM_BASIC, 1'b0, 1'b0, ADDR_RANGE_MAX);
      want_bus <= 1'b1;
      repeat (8) @(posedge clock);
      #1;
      check("ack ignored", release_ack_n, 1'b1);
      $display("test burst select release done");
      // mode 7 never starts a cycle
      do_reset(MODE_7);
      req <= '{1'b1, 1'b0, 2'h1, 24'h200000, 16'h0};
      j = 0;
      repeat (20)
      begin
         @(posedge clock);
         #1;
         j += req_ready;
      end
      check("mode 7 taken", j, 0);
      $display("test mode 7 done");
      wrap_up();
   end
   // watchdog: the run needs well under a thousand cycles
   initial
   begin
      repeat (20000) @(posedge clock);
      err_total++;
      wrap_up();
   end
endmodule
`default_nettype wire
